// ### verilog/dsp_pkg.sv
// Contract
// - Accept one 32-bit parallel instruction word
// - Transfer and processing halves run independently
// - Processing half: dual, conditional, unconditional groups
// - ALU operands limited per role
// - Multiply operands limited per role
// - Unconditional ALU or shift updates flag
// - Conditional operations leave flag unchanged
// - Multiply-only never alters the flag
// - Three-bit condition select picks flag rule
// - Multiply-only writes signed product to destination
// - Dual group: add/subtract plus signed multiply
// - Unconditional add and subtract into destination
// - Arithmetic shift: left non-negative, right negative
// - Logic shift: left non-negative, right negative
// - Copy selected source unchanged into destination
// - Normalize count of selected source to destination
// - Increment upper word of selected source
// - Negate: zero minus selected source
// - Dual moves reach X and Y memory, parallel
// - Carry mode: carry/borrow sets, logical clears except logic shift, which passes its carry
// - Zero mode: all-zero result sets flag
package dsp_pkg;

   localparam logic [5:0] PAR_PREFIX = 6'h3E;
   localparam int PREFIX_HI = 31;
   localparam int PREFIX_LO = 26;
   localparam int XMOVE_HI = 19;
   localparam int XMOVE_LO = 18;
   localparam int YMOVE_HI = 17;
   localparam int YMOVE_LO = 16;
   localparam int SHAMT_HI = 22;
   localparam int SHAMT_LO = 16;

   // Register file indices
   localparam logic [2:0] REG_A0 = 3'h0;
   localparam logic [2:0] REG_A1 = 3'h1;
   localparam logic [2:0] REG_M0 = 3'h2;
   localparam logic [2:0] REG_M1 = 3'h3;
   localparam logic [2:0] REG_X0 = 3'h4;
   localparam logic [2:0] REG_X1 = 3'h5;
   localparam logic [2:0] REG_Y0 = 3'h6;
   localparam logic [2:0] REG_Y1 = 3'h7;

   // Field code 3 in the top slot, code 0 in the bottom slot
   localparam logic [11:0] X_MAP = {REG_A1, REG_A0, REG_X1, REG_X0};
   localparam logic [11:0] Y_MAP = {REG_M1, REG_M0, REG_Y1, REG_Y0};
   localparam logic [11:0] DU_MAP = {REG_A1, REG_A0, REG_Y0, REG_X0};
   localparam logic [11:0] E_MAP = {REG_A1, REG_Y0, REG_X1, REG_X0};
   localparam logic [11:0] F_MAP = {REG_A1, REG_X0, REG_Y1, REG_Y0};
   localparam logic [11:0] G_MAP = {REG_A1, REG_A0, REG_M1, REG_M0};

   localparam logic [1:0] COND_ALWAYS = 2'h1;
   localparam logic [1:0] COND_TRUE = 2'h2;
   localparam logic [1:0] COND_FALSE = 2'h3;

   localparam logic [2:0] CS_CARRY = 3'h0;
   localparam logic [2:0] CS_NEG = 3'h1;
   localparam logic [2:0] CS_ZERO = 3'h2;
   localparam logic [2:0] CS_OVF = 3'h3;
   localparam logic [2:0] CS_GT = 3'h4;
   localparam logic [2:0] CS_GE = 3'h5;

   localparam logic FLAG_RST = 1'b0;
   localparam logic [31:0] REG_RST = 32'h0;

   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_SUB = 4'h2,
      OP_SHA = 4'h3,
      OP_SHL = 4'h4,
      OP_COPY = 4'h5,
      OP_NORM = 4'h6,
      OP_INC = 4'h7,
      OP_NEG = 4'h8
   } alu_op_t;

endpackage

// ### verilog/operand_map.sv
`timescale 1ns/10ps
module operand_map
   #(parameter logic [11:0] MAP = 12'h000)
   (
   input wire logic [1:0] field, // Two-bit operand field
   output logic [2:0] index      // Register file index
   );

   assign index = MAP[3 * field +: 3];
endmodule

// ### verilog/dsp_parallel_op_decoder.sv
`timescale 1ns/10ps
module dsp_parallel_op_decoder
   import dsp_pkg::*;
   (
   input wire logic core_clk,                // Core clock
   input wire logic resetn,                  // Async reset, active low
   input wire logic instr_valid,             // Instruction issued this cycle
   input wire logic [31:0] instr,            // Parallel instruction word
   input wire logic [2:0] condition_select,  // Flag update mode
   input wire logic load_en,                 // Transfer half writes a reg
   input wire logic [2:0] load_idx,          // Transfer half target
   input wire logic [31:0] load_data,        // Transfer half data
   input wire logic [2:0] rd_sel,            // Register read select
   output logic [31:0] rd_data,              // Selected register value
   output logic condition_flag,              // Condition flag
   output logic x_move_req,                  // X memory move requested
   output logic y_move_req,                  // Y memory move requested
   output logic illegal_op                   // Unsupported word seen
   );

   logic [31:0] dsp_reg [8];
   logic [15:0] b;
   logic prefix_ok;
   logic legal;
   logic is_mul;
   logic is_dual;
   logic use_y;
   logic [1:0] cond;
   alu_op_t op;
   logic [2:0] x_idx;
   logic [2:0] y_idx;
   logic [2:0] du_idx;
   logic [2:0] e_idx;
   logic [2:0] f_idx;
   logic [2:0] g_idx;
   logic [2:0] dz_idx;
   logic dz_ok;
   logic [31:0] xv;
   logic [31:0] yv;
   logic [31:0] src;
   logic [31:0] dz_cur;
   logic [32:0] sum33;
   logic [32:0] diff33;
   logic [31:0] prod;
   logic signed [6:0] shamt;
   logic [6:0] mag;
   logic [32:0] lt33;
   logic [32:0] rt33;
   logic [16:0] up17;
   logic [4:0] norm_cnt;
   logic [31:0] alu_res;
   logic cy;
   logic ovf;
   logic logical;
   logic exec;
   logic flag_upd;
   logic next_flag;

   assign b = instr[15:0];
   assign prefix_ok = instr[PREFIX_HI:PREFIX_LO] == PAR_PREFIX;

   // Decode of the processing half
   always_comb
   begin
      op = OP_NONE;
      cond = COND_ALWAYS;
      is_mul = 1'b0;
      is_dual = 1'b0;
      use_y = 1'b0;
      legal = 1'b0;
      if (prefix_ok)
      begin
         if (b[15:12] == 4'h4 && b[7:4] == 4'h0 && b[1:0] == 2'h0)
         begin
            is_mul = 1'b1;
            legal = 1'b1;
         end
         else if (b[15:13] == 3'h3)
         begin
            is_mul = 1'b1;
            is_dual = 1'b1;
            legal = 1'b1;
            op = b[12] ? OP_ADD : OP_SUB;
         end
         else
         begin
            cond = b[9:8];
            legal = b[9:8] != 2'h0;
            unique case (b[15:10])
               6'h2C: op = OP_ADD;
               6'h28: op = OP_SUB;
               6'h24: op = OP_SHA;
               6'h20: op = OP_SHL;
               6'h36: op = OP_COPY;
               6'h3E:
               begin
                  op = OP_COPY;
                  use_y = 1'b1;
               end
               6'h27: op = OP_NORM;
               6'h2F:
               begin
                  op = OP_NORM;
                  use_y = 1'b1;
               end
               6'h26: op = OP_INC;
               6'h2E:
               begin
                  op = OP_INC;
                  use_y = 1'b1;
               end
               6'h32: op = OP_NEG;
               6'h3A:
               begin
                  op = OP_NEG;
                  use_y = 1'b1;
               end
               default: legal = 1'b0;
            endcase
         end
      end
   end

   // Operand selection limited to the registers each role allows
   operand_map #(.MAP(X_MAP)) u_x (.field(b[7:6]), .index(x_idx));
   operand_map #(.MAP(Y_MAP)) u_y (.field(b[5:4]), .index(y_idx));
   operand_map #(.MAP(DU_MAP)) u_du (.field(b[1:0]), .index(du_idx));
   operand_map #(.MAP(E_MAP)) u_e (.field(b[11:10]), .index(e_idx));
   operand_map #(.MAP(F_MAP)) u_f (.field(b[9:8]), .index(f_idx));
   operand_map #(.MAP(G_MAP)) u_g (.field(b[3:2]), .index(g_idx));

   // Codes 8..15 in the destination field are left unmapped
   assign dz_ok = !b[3];
   assign dz_idx = b[2:0];
   assign dz_cur = dsp_reg[dz_idx];
   assign xv = dsp_reg[x_idx];
   assign yv = dsp_reg[y_idx];
   assign src = use_y ? yv : xv;

   assign sum33 = {1'b0, xv} + {1'b0, yv};
   assign diff33 = {1'b0, xv} - {1'b0, yv};
   // Upper words only, so the product fits a 32-bit register
   assign prod = 32'($signed(dsp_reg[e_idx][31:16]) *
                     $signed(dsp_reg[f_idx][31:16]));

   // Amounts beyond 32 simply flush the word
   assign shamt = $signed(yv[SHAMT_HI:SHAMT_LO]);
   assign mag = shamt[6] ? 7'(-shamt) : 7'(shamt);
   assign lt33 = {1'b0, xv} << mag;
   assign rt33 = (op == OP_SHA) ? 33'($signed({xv, 1'b0}) >>> mag)
                                : ({xv, 1'b0} >> mag);
   assign up17 = {1'b0, src[31:16]} + 17'h1;

   // Redundant sign bits below the top bit
   always_comb
   begin
      logic done;
      done = 1'b0;
      norm_cnt = 5'h0;
      for (int i = 30; i >= 0; i--)
      begin
         if (!done && src[i] == src[31])
            norm_cnt = norm_cnt + 5'h1;
         else
            done = 1'b1;
      end
   end

   always_comb
   begin
      alu_res = src;
      cy = 1'b0;
      ovf = 1'b0;
      logical = 1'b0;
      unique case (op)
         OP_NONE: logical = 1'b1;
         OP_ADD:
         begin
            alu_res = sum33[31:0];
            cy = sum33[32];
            ovf = (xv[31] == yv[31]) && (sum33[31] != xv[31]);
         end
         OP_SUB:
         begin
            alu_res = diff33[31:0];
            cy = diff33[32];
            ovf = (xv[31] != yv[31]) && (diff33[31] != xv[31]);
         end
         OP_SHA, OP_SHL:
         begin
            // Carry holds the last bit shifted out
            alu_res = shamt[6] ? rt33[32:1] : lt33[31:0];
            cy = shamt[6] ? rt33[0] : lt33[32];
            logical = op == OP_SHL;
         end
         OP_COPY: logical = 1'b1;
         OP_NORM:
         begin
            alu_res = {11'h0, norm_cnt, 16'h0};
            logical = 1'b1;
         end
         OP_INC:
         begin
            alu_res = {up17[15:0], 16'h0};
            cy = up17[16];
            ovf = !src[31] && up17[15];
         end
         OP_NEG:
         begin
            alu_res = 32'h0 - src;
            cy = src != 32'h0;
            ovf = src[31] && alu_res[31];
         end
      endcase
   end

   assign exec = instr_valid && legal &&
                 (cond == COND_ALWAYS ||
                  (cond == COND_TRUE && condition_flag) ||
                  (cond == COND_FALSE && !condition_flag));
   assign flag_upd = exec && op != OP_NONE &&
                     cond == COND_ALWAYS;

   always_comb
   begin
      next_flag = condition_flag;
      unique case (condition_select)
         // Any shift, logical too, passes its last bit out in this mode
         CS_CARRY: next_flag = (!logical || op == OP_SHL) && cy;
         CS_NEG: next_flag = alu_res[31];
         CS_ZERO: next_flag = alu_res == 32'h0;
         CS_OVF: next_flag = !logical && ovf;
         CS_GT: next_flag = !logical &&
                            !((alu_res[31] ^ ovf) || alu_res == 32'h0);
         CS_GE: next_flag = !logical && !(alu_res[31] ^ ovf);
         default: next_flag = condition_flag;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         condition_flag <= FLAG_RST;
      else if (flag_upd)
         condition_flag <= next_flag;
   end

   // Transfer half lands first; processing results win a collision
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 8; i++)
            dsp_reg[i] <= REG_RST;
      end
      else
      begin
         if (load_en)
            dsp_reg[load_idx] <= load_data;
         if (instr_valid && is_mul)
            dsp_reg[g_idx] <= prod;
         if (exec && is_dual)
            dsp_reg[du_idx] <= alu_res;
         else if (exec && op != OP_NONE && dz_ok)
            dsp_reg[dz_idx] <= alu_res;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         x_move_req <= 1'b0;
         y_move_req <= 1'b0;
         illegal_op <= 1'b0;
         rd_data <= REG_RST;
      end
      else
      begin
         x_move_req <= instr_valid && prefix_ok &&
                       instr[XMOVE_HI:XMOVE_LO] != 2'h0;
         y_move_req <= instr_valid && prefix_ok &&
                       instr[YMOVE_HI:YMOVE_LO] != 2'h0;
         illegal_op <= instr_valid && !legal;
         rd_data <= dsp_reg[rd_sel];
      end
   end

   a_cond_flag_keep: assert property (
      @(posedge core_clk) disable iff (!resetn)
      instr_valid && legal && cond != COND_ALWAYS |=> $stable(condition_flag))
      else $error("conditional op changed the flag");

   a_mul_flag_keep: assert property (
      @(posedge core_clk) disable iff (!resetn)
      instr_valid && is_mul && !is_dual |=> $stable(condition_flag))
      else $error("multiply changed the flag");

   a_zero_mode_flag: assert property (
      @(posedge core_clk) disable iff (!resetn)
      flag_upd && condition_select == CS_ZERO
      |=> condition_flag == ($past(alu_res) == 32'h0))
      else $error("zero mode flag wrong");

   a_carry_mode_add: assert property (
      @(posedge core_clk) disable iff (!resetn)
      flag_upd && condition_select == CS_CARRY && op == OP_ADD
      |=> condition_flag == $past(cy))
      else $error("carry mode flag wrong");

   a_add_dest_write: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec && op == OP_ADD && !is_dual && dz_ok
      |=> dsp_reg[$past(dz_idx)] == $past(sum33[31:0]))
      else $error("add result not written");

   a_untaken_keeps: assert property (
      @(posedge core_clk) disable iff (!resetn)
      instr_valid && legal && !exec && !load_en
      |=> dsp_reg[$past(dz_idx)] == $past(dz_cur) && $stable(condition_flag))
      else $error("untaken conditional op had an effect");

   a_mul_dest_write: assert property (
      @(posedge core_clk) disable iff (!resetn)
      instr_valid && is_mul && !is_dual
      |=> dsp_reg[$past(g_idx)] == $past(prod))
      else $error("product not written");

   a_dual_alu_write: assert property (
      @(posedge core_clk) disable iff (!resetn)
      exec && is_dual |=> dsp_reg[$past(du_idx)] == $past(alu_res))
      else $error("dual ALU result not written");

   a_idle_no_error: assert property (
      @(posedge core_clk) disable iff (!resetn)
      !instr_valid |=> !illegal_op && !x_move_req && !y_move_req)
      else $error("status pulse without an instruction");
endmodule

// ### verification/issue_model.sv
`timescale 1ns/10ps
module issue_model
   (
   input wire logic core_clk,   // Core clock
   input wire logic issue,      // Bench wants a word issued
   input wire logic [31:0] word, // Word to issue
   output logic instr_valid,    // Issue strobe to decoder
   output logic [31:0] instr    // Issued word
   );
   logic [31:0] last;

   // Idle bus flips every cycle so stale words never look valid
   always_ff @(posedge core_clk)
   begin
      if (issue)
         last <= word;
      else
         last <= ~last;
   end

   assign instr_valid = issue;
   assign instr = issue ? word : ~last;
endmodule

// ### verification/tb_dsp_parallel_op_decoder.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         $display("ERROR %s exp %h got %h", nm, exp, got); \
         num_errors++; \
      end \
   end
module tb_dsp_parallel_op_decoder;
   import dsp_pkg::*;
   logic core_clk, resetn, issue, instr_valid, load_en;
   logic [31:0] word, instr, load_data, rd_data;
   logic [2:0] condition_select, load_idx, rd_sel;
   logic condition_flag, x_move_req, y_move_req, illegal_op;
   int num_errors = 0;
   int total_checks = 0;

   always #4 core_clk = ~core_clk;

   issue_model u_cpu (
      .core_clk(core_clk), .issue(issue), .word(word),
      .instr_valid(instr_valid), .instr(instr));

   dsp_parallel_op_decoder u_dut (
      .core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid),
      .instr(instr), .condition_select(condition_select),
      .load_en(load_en), .load_idx(load_idx), .load_data(load_data),
      .rd_sel(rd_sel), .rd_data(rd_data),
      .condition_flag(condition_flag), .x_move_req(x_move_req),
      .y_move_req(y_move_req), .illegal_op(illegal_op));

   task automatic results();
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] pw(logic [15:0] b);
      return {PAR_PREFIX, 6'h00, 4'h0, b};
   endfunction

   task automatic ld(input logic [2:0] i, input logic [31:0] d);
      @(negedge core_clk);
      load_en = 1'b1;
      load_idx = i;
      load_data = d;
      @(negedge core_clk);
      load_en = 1'b0;
   endtask

   task automatic exec(input logic [31:0] w);
      @(negedge core_clk);
      issue = 1'b1;
      word = w;
      @(negedge core_clk);
      issue = 1'b0;
   endtask

   task automatic chk_reg(input logic [2:0] i, input logic [31:0] e);
      @(negedge core_clk);
      rd_sel = i;
      @(negedge core_clk);
      `CHK("reg", e, rd_data)
   endtask

   task automatic op(input logic [15:0] b, input logic [2:0] z,
                     input logic [31:0] e);
      exec(pw(b));
      chk_reg(z, e);
   endtask

   task automatic flag(input logic e);
      `CHK("flag", e, condition_flag)
   endtask

   task automatic pulse(input logic [31:0] w, input logic il,
                        input logic xm, input logic ym);
      exec(w);
      `CHK("illegal", il, illegal_op)
      `CHK("xmove", xm, x_move_req)
      `CHK("ymove", ym, y_move_req)
      @(negedge core_clk);
      `CHK("pulse_end", 1'b0, illegal_op | x_move_req | y_move_req)
   endtask

   task automatic t_add_sub();
      ld(REG_X0, 32'h5);
      ld(REG_Y0, 32'h3);
      ld(REG_X1, 32'h3);
      ld(REG_Y1, 32'h5);
      condition_select = CS_CARRY;
      op(16'hB100, REG_A0, 32'h8);
      flag(1'b0);
      op(16'hA101, REG_A1, 32'h2);
      op(16'hA152, REG_M0, 32'hFFFF_FFFE);
      flag(1'b1);
   endtask

   task automatic t_cond();
      op(16'hB203, REG_M1, 32'h8);
      flag(1'b1);
      op(16'hB305, REG_X1, 32'h3);
      condition_select = CS_ZERO;
      op(16'hA140, REG_A0, 32'h0);
      flag(1'b1);
      op(16'hA101, REG_A1, 32'h2);
      flag(1'b0);
      op(16'hB200, REG_A0, 32'h0);
      op(16'hB300, REG_A0, 32'h8);
      flag(1'b0);
      // Mode 6 keeps the flag even for a zero result
      condition_select = 3'h6;
      op(16'hA140, REG_A0, 32'h0);
      flag(1'b0);
   endtask

   task automatic t_shift();
      condition_select = CS_CARRY;
      ld(REG_X0, 32'h8000_0001);
      ld(REG_Y0, 32'h0001_0000);
      ld(REG_Y1, 32'h007F_0000);
      op(16'h8100, REG_A0, 32'h2);
      flag(1'b1);
      op(16'h8111, REG_A1, 32'h4000_0000);
      flag(1'b1);
      op(16'h9212, REG_M0, 32'hC000_0000);
      op(16'h9313, REG_M1, 32'h8);
      flag(1'b1);
   endtask

   task automatic t_mul();
      ld(REG_X0, 32'hFFFE_0000);
      ld(REG_Y0, 32'h0003_0000);
      op(16'h4000, REG_M0, 32'hFFFF_FFFA);
      flag(1'b1);
      op(16'h7006, REG_A0, 32'h0001_0000);
      chk_reg(REG_M1, 32'hFFFF_FFFA);
      flag(1'b1);
      ld(REG_M0, 32'h0);
      op(16'h6003, REG_A1, 32'hFFFB_0000);
      chk_reg(REG_M0, 32'hFFFF_FFFA);
      flag(1'b0);
   endtask

   task automatic t_unary();
      op(16'hD907, REG_Y1, 32'hFFFE_0000);
      flag(1'b0);
      op(16'hF925, REG_X1, 32'hFFFF_FFFA);
      op(16'hC900, REG_A0, 32'h0002_0000);
      flag(1'b1);
      op(16'h9901, REG_A1, 32'hFFFF_0000);
      flag(1'b0);
      op(16'h9D03, REG_M1, 32'h000E_0000);
      op(16'hE902, REG_M0, 32'hFFFD_0000);
      op(16'hBD04, REG_X0, 32'h000D_0000);
      op(16'hB906, REG_Y0, 32'h0004_0000);
   endtask

   task automatic t_illegal();
      pulse(32'h0000_B100, 1'b1, 1'b0, 1'b0);
      chk_reg(REG_A0, 32'h0002_0000);
      pulse(pw(16'hB500), 1'b1, 1'b0, 1'b0);
      pulse({PAR_PREFIX, 6'h00, 4'h6, 16'hB100}, 1'b0, 1'b1, 1'b1);
      chk_reg(REG_A0, 32'h0011_0000);
      pulse({PAR_PREFIX, 6'h00, 4'h3, 16'hB100}, 1'b0, 1'b0, 1'b1);
   endtask

   // Each remaining flag mode moves the flag the other way
   task automatic t_modes();
      ld(REG_X0, 32'h7FFF_FFFF);
      ld(REG_X1, 32'h0000_0001);
      ld(REG_Y0, 32'h0000_0001);
      condition_select = CS_NEG;
      op(16'hC901, REG_A1, 32'h8000_0001);
      flag(1'b1);
      condition_select = CS_GT;
      op(16'hA143, REG_M1, 32'h0);
      flag(1'b0);
      condition_select = CS_GE;
      op(16'hA143, REG_M1, 32'h0);
      flag(1'b1);
      condition_select = CS_OVF;
      op(16'hA143, REG_M1, 32'h0);
      flag(1'b0);
      op(16'hB102, REG_M0, 32'h8000_0000);
      flag(1'b1);
   endtask

   initial
   begin
      core_clk = 1'b0;
      resetn = 1'b0;
      issue = 1'b0;
      word = 32'h0;
      condition_select = CS_CARRY;
      load_en = 1'b0;
      load_idx = 3'h0;
      load_data = 32'h0;
      rd_sel = 3'h0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      flag(FLAG_RST);
      chk_reg(REG_Y1, REG_RST);
      t_add_sub();
      t_cond();
      t_shift();
      t_mul();
      t_unary();
      t_illegal();
      t_modes();
      results();
   end
endmodule
